// [core/ata_exec_regs.svh]
// Register offsets, field positions, reset values and command codes of the command executor
`ifndef ATA_EXEC_REGS_SVH
`define ATA_EXEC_REGS_SVH
`define OFF_DATA 8'h00
`define OFF_FEAT 8'h04
`define OFF_SCNT 8'h08
`define OFF_SNUM 8'h0c
`define OFF_CYLL 8'h10
`define OFF_CYLH 8'h14
`define OFF_DRV 8'h18
`define OFF_CMD 8'h1c
`define OFF_CTRL 8'h20
`define OFF_ERR 8'h24
`define ST_BSY 7
`define ST_DRDY 6
`define ST_DRQ 3
`define ST_ERR 0
`define ER_UNC 6
`define ER_ABRT 2
`define CTRL_HOB 7
`define DRV_LBA 6
`define RST_DRV 8'ha0
`define CMD_NOP 8'h00
`define CMD_RECAL 4'h1
`define CMD_FLUSH 8'he7
`define CMD_FLUSH_EXT 8'hea
`define CMD_READ 8'h20
`define CMD_READ_RETRY 8'h21
`define CMD_READ_EXT 8'h24
`endif

// [core/ata_exec_pkg.sv]
// Types shared by the command executor
`default_nettype none
package ata_exec_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_RECAL, S_FLUSH, S_NEXT, S_SEEK, S_FILL, S_XFER
  } state_type;
  typedef struct packed {
    logic uncorr;
    logic [31:0] data;
  } media_word_type;
endpackage : ata_exec_pkg
`default_nettype wire

// [core/ata_disk_command_executor.sv]
// Task-file command executor with APB register access and sector buffer
`timescale 1ns/1ns
`default_nettype none
`include "ata_exec_regs.svh"
module ata_disk_command_executor #(
  parameter int WORDS = 128,
  parameter int TRACK_SHIFT = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host flags
  output logic intrq,
  output logic busy_flag,
  output logic data_request_flag,
  // Servo
  output logic seek_req,
  output logic [47:0] seek_target,
  input wire logic seek_done,
  // Write cache
  output logic flush_req,
  input wire logic flush_done,
  // Media read stream
  output logic sector_req,
  output logic [47:0] sector_lba,
  input wire logic media_valid,
  input wire ata_exec_pkg::media_word_type media_word,
  output logic media_ready
);
  localparam int AW = $clog2(WORDS);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [7:0] TF_OFF [5] = '{`OFF_FEAT, `OFF_SCNT, `OFF_SNUM, `OFF_CYLL, `OFF_CYLH};

  ata_exec_pkg::state_type state_q;
  logic [7:0] tf_cur_q [5];
  logic [7:0] tf_prev_q [5];
  logic [7:0] eng_cur [5];
  logic [7:0] eng_prev [5];
  logic [7:0] drv_q;
  logic hob_q;
  logic [47:0] lba_q;
  logic [16:0] cnt_q;
  logic ext_q, err_q, abrt_q, unc_q, sect_unc_q;
  logic irq_ev_q, eng_ld_q, zcyl_q;
  logic [47:0] cur_track_q;
  logic [AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [31:0] ram [WORDS];
  logic [31:0] rd_mux;
  logic rd_mapped;
  logic [7:0] status_byte;

  // APB phases
  logic setup, acc, wr_acc, rd_acc, idle, cmd_go, ext_cmd, last_pop, ram_we, fill_done;
  logic [7:0] cmd;
  logic [47:0] cmd_lba;
  logic [16:0] cmd_cnt;
  assign setup = psel & ~penable;
  assign acc = psel & penable & pready;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign idle = (state_q == ata_exec_pkg::S_IDLE);
  assign cmd = pwdata[7:0];
  assign cmd_go = wr_acc && paddr == `OFF_CMD && idle;
  assign ext_cmd = (cmd == `CMD_READ_EXT);
  assign cmd_lba = ext_cmd ?
      {tf_prev_q[4], tf_prev_q[3], tf_prev_q[2], tf_cur_q[4], tf_cur_q[3], tf_cur_q[2]} :
      {20'h0_0000, drv_q[3:0], tf_cur_q[4], tf_cur_q[3], tf_cur_q[2]};
  // Zero count means the full range
  assign cmd_cnt = ext_cmd ? {~|{tf_prev_q[1], tf_cur_q[1]}, tf_prev_q[1], tf_cur_q[1]} :
      {8'h00, ~|tf_cur_q[1], tf_cur_q[1]};
  assign last_pop = rd_acc && paddr == `OFF_DATA && state_q == ata_exec_pkg::S_XFER &&
      rd_ptr_q == AW'(WORDS - 1);

  // Two-entry buffer between media and sector RAM
  ata_exec_pkg::media_word_type fifo_mem [DEPTH];
  logic [PW-1:0] fwp_q, frp_q;
  logic [CW-1:0] fcnt_q, fcnt_d;
  logic push, pop;
  assign push = media_valid & media_ready;
  assign pop = (fcnt_q != '0) && state_q == ata_exec_pkg::S_FILL;
  assign fcnt_d = fcnt_q + CW'(push) - CW'(pop);
  assign ram_we = pop;
  assign fill_done = ram_we && wr_ptr_q == AW'(WORDS - 1);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      fifo_mem[fwp_q] <= media_word;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fwp_q <= '0;
      frp_q <= '0;
      fcnt_q <= '0;
      media_ready <= 1'b1;
    end else begin
      if (push) begin
        fwp_q <= (fwp_q == PW'(DEPTH - 1)) ? '0 : fwp_q + PW'(1);
      end
      if (pop) begin
        frp_q <= (frp_q == PW'(DEPTH - 1)) ? '0 : frp_q + PW'(1);
      end
      fcnt_q <= fcnt_d;
      media_ready <= (fcnt_d < CW'(DEPTH));
    end
  end

  // Sector RAM
  always_ff @(posedge clk_sys) begin
    if (ram_we) begin
      ram[wr_ptr_q] <= fifo_mem[frp_q].data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      sect_unc_q <= 1'b0;
    end else if (sector_req) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      sect_unc_q <= 1'b0;
    end else begin
      if (ram_we) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
        sect_unc_q <= sect_unc_q | fifo_mem[frp_q].uncorr;
      end
      if (rd_acc && paddr == `OFF_DATA && state_q == ata_exec_pkg::S_XFER) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
    end
  end

  // Values written back to the task file at the end of a read
  always_comb begin
    eng_cur[0] = tf_cur_q[0];
    eng_prev[0] = tf_prev_q[0];
    eng_cur[1] = cnt_q[7:0];
    eng_prev[1] = cnt_q[15:8];
    eng_cur[2] = lba_q[7:0];
    eng_prev[2] = lba_q[31:24];
    eng_cur[3] = lba_q[15:8];
    eng_prev[3] = lba_q[39:32];
    eng_cur[4] = lba_q[23:16];
    eng_prev[4] = lba_q[47:40];
  end

  // Task-file byte pairs
  for (genvar gi = 0; gi < 5; gi++) begin : g_tf
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        tf_cur_q[gi] <= 8'h00;
        tf_prev_q[gi] <= 8'h00;
      end else if (wr_acc && paddr == TF_OFF[gi] && idle) begin
        tf_prev_q[gi] <= tf_cur_q[gi];
        tf_cur_q[gi] <= pwdata[7:0];
      end else if (eng_ld_q && gi != 0) begin
        tf_cur_q[gi] <= eng_cur[gi];
        tf_prev_q[gi] <= ext_q ? eng_prev[gi] : tf_prev_q[gi];
      end else if (zcyl_q && (gi == 3 || gi == 4)) begin
        tf_cur_q[gi] <= 8'h00;
      end
    end
  end

  // Drive/head and byte select
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drv_q <= `RST_DRV;
    end else if (wr_acc && paddr == `OFF_DRV && idle) begin
      drv_q <= pwdata[7:0];
    end else if (eng_ld_q && !ext_q) begin
      drv_q[3:0] <= lba_q[27:24];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hob_q <= 1'b0;
    end else if (wr_acc && paddr == `OFF_CTRL) begin
      hob_q <= pwdata[`CTRL_HOB];
    end else if (wr_acc && idle && paddr >= `OFF_FEAT && paddr <= `OFF_CMD) begin
      hob_q <= 1'b0;
    end
  end

  // Command engine
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ata_exec_pkg::S_IDLE;
      lba_q <= '0;
      cnt_q <= '0;
      ext_q <= 1'b0;
      err_q <= 1'b0;
      abrt_q <= 1'b0;
      unc_q <= 1'b0;
      seek_req <= 1'b0;
      seek_target <= '0;
      flush_req <= 1'b0;
      sector_req <= 1'b0;
      sector_lba <= '0;
      cur_track_q <= '0;
      irq_ev_q <= 1'b0;
      eng_ld_q <= 1'b0;
      zcyl_q <= 1'b0;
    end else begin
      sector_req <= 1'b0;
      irq_ev_q <= 1'b0;
      eng_ld_q <= 1'b0;
      zcyl_q <= 1'b0;
      case (state_q)
        ata_exec_pkg::S_IDLE: begin
          if (cmd_go) begin
            err_q <= 1'b0;
            abrt_q <= 1'b0;
            unc_q <= 1'b0;
            if (cmd[7:4] == `CMD_RECAL) begin
              seek_req <= 1'b1;
              seek_target <= '0;
              state_q <= ata_exec_pkg::S_RECAL;
            end else if (cmd == `CMD_FLUSH || cmd == `CMD_FLUSH_EXT) begin
              flush_req <= 1'b1;
              state_q <= ata_exec_pkg::S_FLUSH;
            end else if ((cmd == `CMD_READ || cmd == `CMD_READ_RETRY || ext_cmd) &&
                (!ext_cmd || drv_q[`DRV_LBA])) begin
              ext_q <= ext_cmd;
              lba_q <= cmd_lba;
              cnt_q <= cmd_cnt;
              state_q <= ata_exec_pkg::S_NEXT;
            end else begin
              // No-op, bad mode and unknown codes abort
              err_q <= 1'b1;
              abrt_q <= 1'b1;
              irq_ev_q <= 1'b1;
            end
          end
        end
        ata_exec_pkg::S_RECAL: begin
          if (seek_done) begin
            seek_req <= 1'b0;
            cur_track_q <= '0;
            zcyl_q <= 1'b1;
            irq_ev_q <= 1'b1;
            state_q <= ata_exec_pkg::S_IDLE;
          end
        end
        ata_exec_pkg::S_FLUSH: begin
          if (flush_done) begin
            flush_req <= 1'b0;
            irq_ev_q <= 1'b1;
            state_q <= ata_exec_pkg::S_IDLE;
          end
        end
        ata_exec_pkg::S_NEXT: begin
          if ((lba_q >> TRACK_SHIFT) != cur_track_q) begin
            seek_req <= 1'b1;
            seek_target <= lba_q >> TRACK_SHIFT;
            state_q <= ata_exec_pkg::S_SEEK;
          end else begin
            sector_req <= 1'b1;
            sector_lba <= lba_q;
            state_q <= ata_exec_pkg::S_FILL;
          end
        end
        ata_exec_pkg::S_SEEK: begin
          if (seek_done) begin
            seek_req <= 1'b0;
            cur_track_q <= seek_target;
            sector_req <= 1'b1;
            sector_lba <= lba_q;
            state_q <= ata_exec_pkg::S_FILL;
          end
        end
        ata_exec_pkg::S_FILL: begin
          if (fill_done) begin
            irq_ev_q <= 1'b1;
            state_q <= ata_exec_pkg::S_XFER;
          end
        end
        ata_exec_pkg::S_XFER: begin
          if (last_pop) begin
            if (sect_unc_q) begin
              err_q <= 1'b1;
              unc_q <= 1'b1;
              eng_ld_q <= 1'b1;
              state_q <= ata_exec_pkg::S_IDLE;
            end else if (cnt_q == 17'h0_0001) begin
              cnt_q <= '0;
              eng_ld_q <= 1'b1;
              state_q <= ata_exec_pkg::S_IDLE;
            end else begin
              cnt_q <= cnt_q - 17'h0_0001;
              lba_q <= lba_q + 48'h0000_0000_0001;
              state_q <= ata_exec_pkg::S_NEXT;
            end
          end
        end
        default: state_q <= ata_exec_pkg::S_IDLE;
      endcase
    end
  end

  // Host flags, intrq set wins over clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_flag <= 1'b0;
      data_request_flag <= 1'b0;
      intrq <= 1'b0;
    end else begin
      busy_flag <= !idle && state_q != ata_exec_pkg::S_XFER;
      data_request_flag <= (state_q == ata_exec_pkg::S_XFER);
      intrq <= irq_ev_q | (intrq & ~(cmd_go | (rd_acc && paddr == `OFF_CMD)));
    end
  end

  // Read mux
  always_comb begin
    status_byte = 8'h00;
    status_byte[`ST_BSY] = busy_flag;
    status_byte[`ST_DRDY] = 1'b1;
    status_byte[`ST_DRQ] = data_request_flag;
    status_byte[`ST_ERR] = err_q;
    rd_mux = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (paddr)
      `OFF_DATA: rd_mux = data_request_flag ? ram[rd_ptr_q] : 32'h0000_0000;
      `OFF_DRV: rd_mux = {24'h00_0000, drv_q};
      `OFF_CMD: rd_mux = {24'h00_0000, status_byte};
      `OFF_CTRL: rd_mux = {24'h00_0000, hob_q, 7'h00};
      `OFF_ERR: rd_mux = {24'h00_0000, 1'b0, unc_q, 3'h0, abrt_q, 2'h0};
      default: rd_mapped = 1'b0;
    endcase
    for (int i = 0; i < 5; i++) begin
      if (paddr == TF_OFF[i]) begin
        rd_mux = {24'h00_0000, hob_q ? tf_prev_q[i] : tf_cur_q[i]};
        rd_mapped = 1'b1;
      end
    end
  end

  // APB answer: no wait state, pready high in the first access cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~rd_mapped;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_fill_end;
    fill_done;
  endsequence
  sequence s_drq_up;
    data_request_flag && !busy_flag && intrq;
  endsequence
  sequence s_final_ok;
    last_pop && !sect_unc_q && cnt_q == 17'h0_0001;
  endsequence

  a_nop_abort: assert property (cmd_go && cmd == `CMD_NOP |=>
      err_q && abrt_q && idle && $stable(tf_cur_q[1]))
    else $error("nop did not abort");
  a_recal_seek: assert property (cmd_go && cmd[7:4] == `CMD_RECAL |=>
      seek_req && seek_target == '0 ##1 busy_flag)
    else $error("recalibrate did not seek to zero");
  a_recal_done: assert property (state_q == ata_exec_pkg::S_RECAL && seek_done |->
      ##2 intrq && !busy_flag && tf_cur_q[3] == 8'h00)
    else $error("recalibrate end wrong");
  a_flush_wait: assert property (state_q == ata_exec_pkg::S_FLUSH && !flush_done |=>
      flush_req && state_q == ata_exec_pkg::S_FLUSH)
    else $error("flush ended early");
  a_flush_ext: assert property (cmd_go && cmd == `CMD_FLUSH_EXT |=> flush_req)
    else $error("extended flush not taken");
  a_read_count: assert property (cmd_go && cmd == `CMD_READ |=>
      cnt_q == $past(cmd_cnt) && cnt_q != '0 && cnt_q <= 17'h0_0100)
    else $error("read count wrong");
  a_drq_raise: assert property (s_fill_end |-> ##2 s_drq_up)
    else $error("no data request after fill");
  a_next_busy: assert property (last_pop && !sect_unc_q && cnt_q > 17'h0_0001 |->
      ##2 busy_flag && !data_request_flag)
    else $error("no busy between sectors");
  a_unc_stop: assert property (last_pop && sect_unc_q |=>
      idle && err_q && unc_q ##1 tf_cur_q[2] == lba_q[7:0])
    else $error("uncorrectable did not stop");
  a_no_final_irq: assert property (s_final_ok |=> !irq_ev_q [*2])
    else $error("interrupt after final sector");
  a_ext_count: assert property (cmd_go && ext_cmd && drv_q[`DRV_LBA] |=>
      ext_q && cnt_q == $past(cmd_cnt) && lba_q == $past(cmd_lba))
    else $error("extended read load wrong");
  a_ext_lba_only: assert property (cmd_go && ext_cmd && !drv_q[`DRV_LBA] |=>
      abrt_q && idle)
    else $error("extended read in chs mode");
  a_ext_unc_addr: assert property (last_pop && sect_unc_q && ext_q |->
      ##2 tf_prev_q[2] == lba_q[31:24] && idle)
    else $error("extended failing address lost");
  a_hob_read: assert property (setup && !pwrite && paddr == `OFF_SCNT && hob_q |=>
      prdata[7:0] == $past(tf_prev_q[1]))
    else $error("hob select read wrong");
  a_done_zero: assert property (s_final_ok |-> ##2 tf_cur_q[1] == 8'h00)
    else $error("count not zero at end");
endmodule : ata_disk_command_executor
`default_nettype wire

// [test/media_model.sv]
// Servo, write cache and media stream model at the executor's far side
`timescale 1ns/1ns
`default_nettype none
module media_model #(
  parameter int WORDS = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Servo and cache
  input wire logic seek_req,
  output logic seek_done,
  input wire logic flush_req,
  output logic flush_done,
  // Media stream
  input wire logic sector_req,
  input wire logic [47:0] sector_lba,
  output logic media_valid,
  output ata_exec_pkg::media_word_type media_word,
  input wire logic media_ready,
  // Scenario controls
  input wire logic [47:0] bad_lba,
  input wire logic slow
);
  logic [7:0] wait_q;
  logic [15:0] left_q;
  logic [47:0] lba_q;
  logic ph_q;
  // Seek and flush finish a fixed while after the request
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 8'h00;
      seek_done <= 1'b0;
      flush_done <= 1'b0;
    end else begin
      wait_q <= (seek_req || flush_req) ? wait_q + 8'h01 : 8'h00;
      seek_done <= seek_req && wait_q == 8'h08;
      flush_done <= flush_req && wait_q == 8'h0c;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      left_q <= 16'h0000;
      lba_q <= 48'h0;
      ph_q <= 1'b0;
    end else begin
      ph_q <= !ph_q;
      if (sector_req) begin
        left_q <= 16'(WORDS);
        lba_q <= sector_lba;
      end else if (media_valid && media_ready) begin
        left_q <= left_q - 16'h0001;
      end
    end
  end
  // Idle lines show the inverse, never a stale word
  always_comb begin
    media_valid = left_q != 16'h0000 && (!slow || ph_q);
    media_word = {lba_q == bad_lba && left_q == 16'h0001, lba_q[15:0], left_q};
    if (!media_valid) begin
      media_word = ~media_word;
    end
  end
endmodule : media_model
`default_nettype wire

// [test/ata_disk_command_executor_tb_top.sv]
// Self-checking bench for the task-file command executor
`timescale 1ns/1ns
`default_nettype none
`include "ata_exec_regs.svh"
module ata_disk_command_executor_tb_top;
  localparam int WORDS = 4;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, intrq, busy_flag, data_request_flag;
  logic seek_req, seek_done, flush_req, flush_done, sector_req, media_valid, media_ready;
  logic [47:0] seek_target, sector_lba, lba;
  logic [47:0] bad_lba = 48'hffff_ffff_ffff;
  logic slow = 1'b0;
  ata_exec_pkg::media_word_type media_word;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] seed = 32'h7870;
  logic [7:0] codes[4] = '{8'h10, 8'h1f, 8'he7, 8'hea};
  logic seen;
  int errors = 0;
  int n_checks = 0;
  always #5 clk_sys = ~clk_sys;
  ata_disk_command_executor #(.WORDS(WORDS)) dut (.clk_sys, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .intrq, .busy_flag,
    .data_request_flag, .seek_req, .seek_target, .seek_done, .flush_req, .flush_done,
    .sector_req, .sector_lba, .media_valid, .media_word, .media_ready);
  media_model #(.WORDS(WORDS)) far_end (.clk_sys, .resetn, .seek_req, .seek_done,
    .flush_req, .flush_done, .sector_req, .sector_lba, .media_valid, .media_word,
    .media_ready, .bad_lba, .slow);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      chk("pready wait", 1, 0);
      test_done();
    end
    chk("pslverr", a == 8'h30, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 32'h0, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m);
  endtask : rd
  // Read results are matched against the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) begin
        chk("read note", 1, 0);
      end else begin
        chk("prdata", exp_q[0] & msk_q[0], prdata & msk_q[0]);
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end
  task automatic wait_irq();
    int i;
    for (i = 0; i < 3000 && intrq !== 1'b1; i++) @(posedge clk_sys);
    if (intrq !== 1'b1) begin
      chk("intrq wait", 1, intrq);
      test_done();
    end
  endtask : wait_irq
  // Both bytes of the count, sector and cylinder registers, previous first, then drive/head
  task automatic load(input logic [47:0] l, input logic [15:0] c, input logic [7:0] drv);
    wr(`OFF_SCNT, c[15:8]);
    wr(`OFF_SCNT, c[7:0]);
    wr(`OFF_SNUM, l[31:24]);
    wr(`OFF_SNUM, l[7:0]);
    wr(`OFF_CYLL, l[39:32]);
    wr(`OFF_CYLL, l[15:8]);
    wr(`OFF_CYLH, l[47:40]);
    wr(`OFF_CYLH, l[23:16]);
    wr(`OFF_DRV, drv);
  endtask : load
  task automatic take(input logic [47:0] l, input logic last);
    int i;
    wait_irq();
    chk("data request", 1, data_request_flag);
    chk("busy", 0, busy_flag);
    rd(`OFF_CMD, 32'h48, 32'hc9);
    for (i = 0; i < WORDS; i++) rd(`OFF_DATA, {l[15:0], 16'(WORDS - i)}, '1);
    repeat (3) @(posedge clk_sys);
    chk("data request", 0, data_request_flag);
    chk("busy", !last, busy_flag);
  endtask : take
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(`OFF_CMD, 32'h40, 32'hff);
    rd(`OFF_DRV, `RST_DRV, 32'hff);
    rd(8'h30, 32'h0, '1);
    $display("Test reset done");
    seed = lfsr(seed);
    wr(`OFF_SNUM, seed[7:0]);
    wr(`OFF_CYLL, seed[15:8]);
    wr(`OFF_CYLH, seed[23:16]);
    wr(`OFF_CMD, `CMD_NOP);
    wait_irq();
    rd(`OFF_CMD, 32'h01, 32'h81);
    rd(`OFF_ERR, 32'h04, 32'h04);
    rd(`OFF_SNUM, {24'h0, seed[7:0]}, 32'hff);
    rd(`OFF_CYLL, {24'h0, seed[15:8]}, 32'hff);
    rd(`OFF_CYLH, {24'h0, seed[23:16]}, 32'hff);
    $display("Test nop done");
    for (int k = 0; k < 4; k++) begin
      wr(`OFF_CMD, codes[k]);
      repeat (2) @(posedge clk_sys);
      chk("busy", 1, busy_flag);
      chk("servo or cache", 1, k < 2 ? seek_req : flush_req);
      if (k < 2) chk("seek target", 0, seek_target);
      wait_irq();
      chk("busy", 0, busy_flag);
      rd(`OFF_CMD, 32'h40, 32'hc9);
    end
    $display("Test recalibrate and flush done");
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      slow <= seed[0];
      lba = 48'h2_34ff;
      load(lba, 16'(2 - k), 8'he0);
      wr(`OFF_CMD, k == 0 ? `CMD_READ : `CMD_READ_RETRY);
      take(lba, k == 1);
      if (k == 0) take(lba + 48'h1, 1'b1);
      seen = 1'b0;
      for (int i = 0; i < 20; i++) begin
        @(posedge clk_sys);
        seen = seen | intrq;
      end
      chk("final interrupt", 0, seen);
      rd(`OFF_SCNT, 32'h0, 32'hff);
      rd(`OFF_SNUM, (k == 0) ? 32'h00 : 32'hff, 32'hff);
      rd(`OFF_CYLL, (k == 0) ? 32'h35 : 32'h34, 32'hff);
    end
    $display("Test read done");
    lba = 48'h3456_789a_bcfe;
    load(lba, 16'h0003, 8'ha0);
    wr(`OFF_CMD, `CMD_READ_EXT);
    wait_irq();
    rd(`OFF_CMD, 32'h01, 32'h81);
    rd(`OFF_ERR, 32'h04, 32'h04);
    load(lba, 16'h0003, 8'he0);
    wr(`OFF_CTRL, 8'h80);
    rd(`OFF_SCNT, 32'h00, 32'hff);
    rd(`OFF_SNUM, {24'h0, lba[31:24]}, 32'hff);
    rd(`OFF_CYLH, {24'h0, lba[47:40]}, 32'hff);
    wr(`OFF_CTRL, 8'h00);
    rd(`OFF_SNUM, {24'h0, lba[7:0]}, 32'hff);
    bad_lba <= lba + 48'h1;
    slow <= 1'b1;
    wr(`OFF_CMD, `CMD_READ_EXT);
    take(lba, 1'b0);
    take(lba + 48'h1, 1'b1);
    rd(`OFF_ERR, 32'h40, 32'h40);
    rd(`OFF_CMD, 32'h01, 32'h81);
    rd(`OFF_SNUM, 32'hff, 32'hff);
    rd(`OFF_CYLL, 32'hbc, 32'hff);
    rd(`OFF_SCNT, 32'h02, 32'hff);
    $display("Test extended read done");
    test_done();
  end
endmodule : ata_disk_command_executor_tb_top
`default_nettype wire
